// *** src/odpps_pkg.sv ***
package odpps_pkg;
    // pin numbering on the pin vectors
    localparam int NPINS         = 14;
    localparam int BIT_LO        = 0;
    localparam int P0_LO         = 4;
    localparam int P1_LO         = 8;
    localparam int P2_LO         = 12;
    localparam int BIT_W         = 4;
    localparam int NIB_W         = 4;
    localparam int P2_W          = 2;
    // alias pins sit on bit-port bits 2 and 3
    localparam int ALIAS_C_BIT   = 2;
    localparam int ALIAS_K_BIT   = 3;
    // shared pins inside port one
    localparam int TIMER_PIN_BIT = 2;
    localparam int IRQ_PIN_BIT   = 3;
    localparam int ANALOG_IN_ZERO_BIT      = 0;
    localparam int ANALOG_IN_ONE_BIT      = 1;
    // interrupt control register
    localparam int IRQ_CTRL_W    = 4;
    localparam int IRQ_GATE_POS  = 3;
    localparam logic [IRQ_CTRL_W-1:0] IRQ_CTRL_RST = 4'h0;
    // latches come out of reset released, pins float as inputs
    localparam logic [NPINS-1:0] LATCH_RST = 14'h3FFF;
    localparam logic [NPINS-1:0] CFG_RST   = 14'h0000;
    // bit-port bits 0 and 1 own no pull-up and no key-on wakeup
    localparam logic [NPINS-1:0] CFG_MASK  = 14'h3FFC;
endpackage

// *** src/odpps_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module odpps_sync #(
    parameter int W = 14
) (
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // released pins read high, so reset to ones
    always_ff @(posedge mclk) begin
        if (reset) begin
            meta_q   <= '1;
            sync_out <= '1;
        end else begin
            meta_q   <= meta_d;
            sync_out <= sync_d;
        end
    end
endmodule
`default_nettype wire

// *** src/odpps_tdiv.sv ***
`timescale 1ns/1ps
`default_nettype none
module odpps_tdiv (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic src_sel,
    input  wire logic uf_one,
    input  wire logic uf_two,
    output var  logic div_q
);
    logic div_d;

    always_comb begin
        div_d = div_q;
        if (src_sel ? uf_two : uf_one) begin
            div_d = ~div_q;
        end
    end

    // starts high so a fresh output selection leaves the pin released
    always_ff @(posedge mclk) begin
        if (reset) begin
            div_q <= 1'b1;
        end else begin
            div_q <= div_d;
        end
    end
endmodule
`default_nettype wire

// *** src/odpps_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module odpps_top (
    input  wire logic                                  mclk,
    input  wire logic                                  reset,
    // pins: 0-3 bit port, 4-7 port zero, 8-11 port one, 12-13 port two
    input  wire logic [odpps_pkg::NPINS-1:0]           pin_in,
    output var  logic [odpps_pkg::NPINS-1:0]           pin_out,
    output var  logic [odpps_pkg::NPINS-1:0]           pin_oe,
    output var  logic [odpps_pkg::NPINS-1:0]           pullup_on,
    // bit port
    input  wire logic                                  bit_wr,
    input  wire logic [1:0]                            bit_idx,
    input  wire logic                                  bit_wdata,
    output var  logic [odpps_pkg::BIT_W-1:0]           bit_port_pins,
    input  wire logic                                  skip_req,
    input  wire logic [1:0]                            skip_idx,
    input  wire logic                                  skip_on_high,
    output var  logic                                  skip_q,
    output var  logic                                  skip_valid_q,
    // single-bit alias ports
    input  wire logic                                  alias_c_wr,
    input  wire logic                                  alias_c_wdata,
    output var  logic                                  alias_c_rdata,
    input  wire logic                                  alias_k_wr,
    input  wire logic                                  alias_k_wdata,
    output var  logic                                  alias_k_rdata,
    // nibble and two-bit ports
    input  wire logic                                  p0_wr,
    input  wire logic [odpps_pkg::NIB_W-1:0]           p0_wdata,
    output var  logic [odpps_pkg::NIB_W-1:0]           nibble_port_zero,
    input  wire logic                                  p1_wr,
    input  wire logic [odpps_pkg::NIB_W-1:0]           p1_wdata,
    output var  logic [odpps_pkg::NIB_W-1:0]           nibble_port_one,
    input  wire logic                                  p2_wr,
    input  wire logic [odpps_pkg::P2_W-1:0]            p2_wdata,
    output var  logic [odpps_pkg::P2_W-1:0]            two_bit_port,
    // pull-up and key-on wakeup enables
    input  wire logic                                  cfg_wr,
    input  wire logic [odpps_pkg::NPINS-1:0]           pullup_wdata,
    input  wire logic [odpps_pkg::NPINS-1:0]           key_wdata,
    output var  logic [odpps_pkg::NPINS-1:0]           key_en_q,
    output var  logic                                  wake_req_q,
    // interrupt control
    input  wire logic                                  irq_ctrl_wr,
    input  wire logic [odpps_pkg::IRQ_CTRL_W-1:0]      irq_ctrl_wdata,
    output var  logic [odpps_pkg::IRQ_CTRL_W-1:0]      irq_control_reg,
    output var  logic                                  ext_irq_q,
    // timer pin
    input  wire logic                                  timer_out_sel,
    input  wire logic                                  timer_src_sel,
    input  wire logic                                  timer1_uf,
    input  wire logic                                  timer2_uf,
    output var  logic                                  timer_evt_q,
    // analog selection
    input  wire logic [1:0]                            adc_sel,
    output var  logic                                  analog_in_zero,
    output var  logic                                  analog_in_one
);
    localparam int NP  = odpps_pkg::NPINS;
    localparam int TMR = odpps_pkg::P1_LO + odpps_pkg::TIMER_PIN_BIT;
    localparam int IRQ = odpps_pkg::P1_LO + odpps_pkg::IRQ_PIN_BIT;
    localparam int PC  = odpps_pkg::BIT_LO + odpps_pkg::ALIAS_C_BIT;
    localparam int PK  = odpps_pkg::BIT_LO + odpps_pkg::ALIAS_K_BIT;

    logic [NP-1:0]  pin_s;
    logic           tdiv_q;

    logic [NP-1:0]  latch_q;
    logic [NP-1:0]  latch_d;
    logic [NP-1:0]  pu_d;
    logic [NP-1:0]  key_d;
    logic [NP-1:0]  oe_d;
    logic [odpps_pkg::IRQ_CTRL_W-1:0] irq_ctrl_d;

    logic           tmr_prev_q;
    logic           skip_d;
    logic           skip_valid_d;
    logic           wake_d;
    logic           ext_irq_d;
    logic           tmr_evt_d;

    // every pin level crosses in through two flops
    odpps_sync #(
        .W        (NP)
    ) u_sync (
        .mclk     (mclk),
        .reset    (reset),
        .async_in (pin_in),
        .sync_out (pin_s)
    );

    odpps_tdiv u_tdiv (
        .mclk    (mclk),
        .reset   (reset),
        .src_sel (timer_src_sel),
        .uf_one  (timer1_uf),
        .uf_two  (timer2_uf),
        .div_q   (tdiv_q)
    );

    // output latches and configuration
    always_comb begin
        latch_d    = latch_q;
        pu_d       = pullup_on;
        key_d      = key_en_q;
        irq_ctrl_d = irq_control_reg;
        if (bit_wr) begin
            latch_d[odpps_pkg::BIT_LO + int'(bit_idx)] = bit_wdata;
        end
        // alias writes land on the same latch as the bit port
        if (alias_c_wr) begin
            latch_d[PC] = alias_c_wdata;
        end
        if (alias_k_wr) begin
            latch_d[PK] = alias_k_wdata;
        end
        if (p0_wr) begin
            latch_d[odpps_pkg::P0_LO +: odpps_pkg::NIB_W] = p0_wdata;
        end
        if (p1_wr) begin
            latch_d[odpps_pkg::P1_LO +: odpps_pkg::NIB_W] = p1_wdata;
        end
        if (p2_wr) begin
            latch_d[odpps_pkg::P2_LO +: odpps_pkg::P2_W] = p2_wdata;
        end
        if (cfg_wr) begin
            pu_d  = pullup_wdata & odpps_pkg::CFG_MASK;
            key_d = key_wdata & odpps_pkg::CFG_MASK;
        end
        if (irq_ctrl_wr) begin
            irq_ctrl_d = irq_ctrl_wdata;
        end
    end

    // open-drain drive: a pin is pulled low only, never driven high
    always_comb begin
        oe_d = ~latch_d;
        // timer output halves the underflow rate; latch 0 still wins
        if (timer_out_sel && !tdiv_q) begin
            oe_d[TMR] = 1'b1;
        end
    end

    // input side: skip, wakeup, interrupt, event count
    always_comb begin
        skip_valid_d = skip_req;
        skip_d       = 1'b0;
        if (skip_req) begin
            skip_d = pin_s[odpps_pkg::BIT_LO + int'(skip_idx)]
                     == skip_on_high;
        end
        // pull-up advice for keyed pins is software's job
        wake_d    = |(~pin_s & key_en_q);
        ext_irq_d = ~pin_s[IRQ]
                    & irq_control_reg[odpps_pkg::IRQ_GATE_POS];
        // counts only while the pin is an input; own output is not counted
        tmr_evt_d = pin_s[TMR] & ~tmr_prev_q & ~timer_out_sel;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            latch_q         <= odpps_pkg::LATCH_RST;
            pin_oe          <= '0;
            pin_out         <= '0;
            pullup_on       <= odpps_pkg::CFG_RST;
            key_en_q        <= odpps_pkg::CFG_RST;
            irq_control_reg <= odpps_pkg::IRQ_CTRL_RST;
        end else begin
            latch_q         <= latch_d;
            pin_oe          <= oe_d;
            pin_out         <= '0;
            pullup_on       <= pu_d;
            key_en_q        <= key_d;
            irq_control_reg <= irq_ctrl_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            skip_q       <= 1'b0;
            skip_valid_q <= 1'b0;
            wake_req_q   <= 1'b0;
            ext_irq_q    <= 1'b0;
            tmr_prev_q   <= 1'b1;
            timer_evt_q  <= 1'b0;
        end else begin
            skip_q       <= skip_d;
            skip_valid_q <= skip_valid_d;
            wake_req_q   <= wake_d;
            ext_irq_q    <= ext_irq_d;
            tmr_prev_q   <= pin_s[TMR];
            timer_evt_q  <= tmr_evt_d;
        end
    end

    // read paths follow the pins whatever alternate function is chosen
    always_ff @(posedge mclk) begin
        if (reset) begin
            bit_port_pins    <= '1;
            alias_c_rdata    <= 1'b1;
            alias_k_rdata    <= 1'b1;
            nibble_port_zero <= '1;
            nibble_port_one  <= '1;
            two_bit_port     <= '1;
            analog_in_zero   <= 1'b0;
            analog_in_one    <= 1'b0;
        end else begin
            bit_port_pins    <= pin_s[odpps_pkg::BIT_LO +: odpps_pkg::BIT_W];
            alias_c_rdata    <= pin_s[PC];
            alias_k_rdata    <= pin_s[PK];
            nibble_port_zero <= pin_s[odpps_pkg::P0_LO +: odpps_pkg::NIB_W];
            nibble_port_one  <= pin_s[odpps_pkg::P1_LO +: odpps_pkg::NIB_W];
            two_bit_port     <= pin_s[odpps_pkg::P2_LO +: odpps_pkg::P2_W];
            analog_in_zero   <= adc_sel[odpps_pkg::ANALOG_IN_ZERO_BIT];
            analog_in_one    <= adc_sel[odpps_pkg::ANALOG_IN_ONE_BIT];
        end
    end
endmodule
`default_nettype wire

// *** bench/odpps_chk_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module odpps_chk (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic [13:0] pin_out,
    input wire logic [13:0] pin_oe,
    input wire logic [13:0] pullup_on,
    input wire logic [13:0] key_en_q,
    input wire logic        bit_wr,
    input wire logic [1:0]  bit_idx,
    input wire logic        bit_wdata,
    input wire logic        alias_c_wr,
    input wire logic        alias_k_wr,
    input wire logic        cfg_wr,
    input wire logic [13:0] pullup_wdata,
    input wire logic [13:0] key_wdata,
    input wire logic        skip_req,
    input wire logic [1:0]  skip_idx,
    input wire logic        skip_on_high,
    input wire logic        skip_q,
    input wire logic        skip_valid_q,
    input wire logic [3:0]  bit_port_pins,
    input wire logic        irq_ctrl_wr,
    input wire logic [3:0]  irq_ctrl_wdata,
    input wire logic [3:0]  irq_control_reg,
    input wire logic        ext_irq_q,
    input wire logic        wake_req_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_no_keys; (key_en_q == 14'h0000)[*4]; endsequence
    sequence s_answer;
        skip_valid_q && skip_q ==
            (bit_port_pins[$past(skip_idx)] == $past(skip_on_high));
    endsequence
    property p_pout; pin_out == 14'h0000; endproperty
    a_pout: assert property (p_pout) else $error("pin data not low");
    property p_bit; bit_wr && !alias_c_wr && !alias_k_wr
        |=> pin_oe[$past(bit_idx)] == !$past(bit_wdata); endproperty
    a_bit: assert property (p_bit) else $error("bit latch wrong");
    property p_cfg; cfg_wr |=> pullup_on == ($past(pullup_wdata) & 14'h3FFC)
        && key_en_q == ($past(key_wdata) & 14'h3FFC); endproperty
    a_cfg: assert property (p_cfg) else $error("enables wrong");
    property p_skip; skip_req |=> s_answer; endproperty
    a_skip: assert property (p_skip) else $error("skip answer wrong");
    property p_pulse; !skip_req |=> !skip_valid_q; endproperty
    a_pulse: assert property (p_pulse) else $error("stray skip");
    property p_gate; !irq_control_reg[3] |=> !ext_irq_q; endproperty
    a_gate: assert property (p_gate) else $error("gate ignored");
    property p_irqw; irq_ctrl_wr |=> irq_control_reg == $past(irq_ctrl_wdata);
    endproperty
    a_irqw: assert property (p_irqw) else $error("irq ctrl wrong");
    property p_wake; s_no_keys |-> !wake_req_q; endproperty
    a_wake: assert property (p_wake) else $error("stray wakeup");
endmodule
bind odpps_top odpps_chk odpps_chk_i (.*);
`default_nettype wire

// *** bench/odpps_board.sv ***
`timescale 1ns/1ps
`default_nettype none
module odpps_board (
    input  wire logic [13:0] pin_oe,
    input  wire logic [13:0] key_low,
    output var  logic [13:0] pin_in
);
    // board resistors lift every released line; any party pulling wins
    assign pin_in = ~(pin_oe | key_low);
endmodule
`default_nettype wire

// *** bench/test_open_drain_port_pin_sharing.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_open_drain_port_pin_sharing;
    logic mclk, reset, bit_wr, bit_wdata, skip_req, skip_on_high, skip_q;
    logic skip_valid_q, alias_c_wr, alias_c_wdata, alias_c_rdata, alias_k_wr;
    logic alias_k_wdata, alias_k_rdata, p0_wr, p1_wr, p2_wr, cfg_wr;
    logic wake_req_q, irq_ctrl_wr, ext_irq_q, timer_out_sel, timer_src_sel;
    logic timer1_uf, timer2_uf, timer_evt_q, analog_in_zero, analog_in_one;
    logic [1:0]  bit_idx, skip_idx, p2_wdata, two_bit_port, adc_sel;
    logic [3:0]  bit_port_pins, p0_wdata, nibble_port_zero, p1_wdata;
    logic [3:0]  nibble_port_one, irq_ctrl_wdata, irq_control_reg;
    logic [13:0] pin_in, pin_out, pin_oe, pullup_on, pullup_wdata;
    logic [13:0] key_wdata, key_en_q, key_low, lat;
    logic [41:0] rows [5];
    int          bad_count = 0;
    int          checks_done = 0;
    int          i;
    odpps_top odpps_top_i (.*);
    odpps_board odpps_board_i (.*);
    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // software releases a latch with 1 before using the pin as input
    task automatic put(input logic [13:0] l);
        {p2_wr, p1_wr, p0_wr, bit_wr} = 4'hF;
        {p2_wdata, p1_wdata, p0_wdata} = l[13:4];
        for (int b = 0; b < 4; b++) begin
            bit_idx = b[1:0];
            bit_wdata = l[b];
            cyc(1);
        end
        {p2_wr, p1_wr, p0_wr, bit_wr} = 4'h0;
    endtask
    initial begin
        #20us;
        bad_count++;
        results;
    end
    initial begin
        reset = 1;
        {bit_wr, bit_wdata, skip_req, skip_on_high, alias_c_wr, alias_c_wdata,
         alias_k_wr, alias_k_wdata, p0_wr, p1_wr, p2_wr, cfg_wr, irq_ctrl_wr,
         timer_out_sel, timer_src_sel, timer1_uf, timer2_uf, bit_idx, skip_idx,
         p0_wdata, p1_wdata, p2_wdata, pullup_wdata, key_wdata,
         irq_ctrl_wdata, key_low} = '0;
        adc_sel = 2'h3;
        rows = '{{14'h3FFF, 14'h0000, 14'h3FFF}, {14'h0000, 14'h0000, 14'h0000},
                 {14'h3FFF, 14'h2A55, 14'h15AA}, {14'h1555, 14'h0000, 14'h1555},
                 {14'h2AAA, 14'h1555, 14'h2AAA}};
        cyc(5);
        reset = 0;
        chk(pin_oe | pullup_on | key_en_q | pin_out, 14'h0000);
        chk(irq_control_reg, 14'h0000);
        foreach (rows[r]) begin
            {lat, key_low} = rows[r][41:14];
            put(lat);
            cyc(4);
            chk(pin_oe, ~lat);
            chk({two_bit_port, nibble_port_one, nibble_port_zero,
                 bit_port_pins}, rows[r][13:0]);
            chk({alias_k_rdata, alias_c_rdata}, rows[r][3:2]);
        end
        put(14'h3FFF);
        key_low = 14'h000A;
        cyc(4);
        skip_req = 1;
        for (int k = 0; k < 8; k++) begin
            skip_idx = k[1:0];
            skip_on_high = k[2];
            cyc(1);
            chk({skip_valid_q, skip_q},
                {1'b1, !key_low[k[1:0]] == k[2]});
        end
        {skip_req, key_low} = 0;
        // bit write of 0 on bit 3 loses to the alias write of 1
        {bit_wr, bit_wdata, bit_idx, alias_k_wr, alias_k_wdata,
         alias_c_wr} = 7'h5F;
        cyc(1);
        {bit_wr, alias_k_wr, alias_c_wr} = 0;
        chk(pin_oe[3:0], 4'h4);
        cyc(3);
        chk({alias_k_rdata, alias_c_rdata, bit_port_pins[2]}, 3'h4);
        // pull-up goes on with every key enable
        {pullup_wdata, key_wdata, cfg_wr} = {14'h3FFF, 14'h3FFF, 1'b1};
        cyc(1);
        cfg_wr = 0;
        chk(pullup_on, 14'h3FFC);
        chk(key_en_q, 14'h3FFC);
        cyc(3);
        chk(wake_req_q, 1);
        {alias_c_wr, alias_c_wdata, key_low} = {2'h3, 14'h0001};
        cyc(1);
        alias_c_wr = 0;
        cyc(4);
        chk(wake_req_q, 0);
        key_low = 14'h0800;
        cyc(4);
        chk(ext_irq_q, 0);
        {irq_ctrl_wr, irq_ctrl_wdata} = 5'h18;
        cyc(1);
        irq_ctrl_wr = 0;
        chk(irq_control_reg, 14'h0008);
        cyc(2);
        chk({ext_irq_q, wake_req_q, nibble_port_one[3]}, 3'h6);
        {key_low, timer_out_sel, timer2_uf} = {14'h0000, 2'h3};
        cyc(1);
        timer2_uf = 0;
        cyc(2);
        chk(pin_oe[10], 14'h0000);
        for (int k = 0; k < 2; k++) begin
            timer1_uf = 1;
            cyc(1);
            timer1_uf = 0;
            cyc(5);
            chk({pin_oe[10], nibble_port_one[2]},
                k ? 2'h1 : 2'h2);
        end
        // second timer as source: two pulses, low then released again
        timer_src_sel = 1;
        for (int k = 0; k < 2; k++) begin
            timer2_uf = 1;
            cyc(1);
            timer2_uf = 0;
            cyc(2);
            chk(pin_oe[10], k ? 14'h0000 : 14'h0001);
        end
        timer_out_sel = 0;
        key_low[10] = 1;
        cyc(4);
        key_low[10] = 0;
        i = 0;
        while (timer_evt_q !== 1'b1 && i < 6) begin
            cyc(1);
            i++;
        end
        chk(timer_evt_q, 14'h0001);
        chk({analog_in_one, analog_in_zero}, 2'h3);
        adc_sel = 2'h1;
        cyc(2);
        chk({analog_in_one, analog_in_zero}, 2'h1);
        results;
    end
endmodule
`default_nettype wire
